// >>> design/sab_brake_timer.sv
// sab_brake_timer: delays brake release after the drive is enabled
// assumes enable_i is synchronous; delay is sampled when enable rises
`timescale 1ns/1ps
`default_nettype none
module sab_brake_timer
  import sab_pkg::*;
#(
  parameter int CYCLES_PER_MS_P = CYCLES_PER_MS
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [7:0] delay_ms_i,
  output logic release_o
);

  localparam logic [24:0] MS_LAST = 25'(CYCLES_PER_MS_P - 1);

  sab_brake_e state_reg;
  sab_brake_e state_next;
  logic enable_d_reg;
  logic [24:0] cyc_reg;
  logic [24:0] cyc_next;
  logic [7:0] ms_left_reg;
  logic [7:0] ms_left_next;
  logic enable_rise;
  logic ms_tick;

  assign enable_rise = enable_i && !enable_d_reg;
  assign ms_tick = cyc_reg == MS_LAST;

  always_comb begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    ms_left_next = ms_left_reg;
    case (state_reg)
      BRK_HELD: begin
        if (enable_rise) begin
          cyc_next = 25'h000_0000;
          ms_left_next = delay_ms_i;
          state_next = (delay_ms_i == 8'h00) ? BRK_OPEN : BRK_WAIT; // RULE6
        end
      end
      BRK_WAIT: begin
        cyc_next = ms_tick ? 25'h000_0000 : cyc_reg + 25'h000_0001;
        if (ms_tick) begin
          ms_left_next = ms_left_reg - 8'h01;
          if (ms_left_reg == 8'h01) begin
            state_next = BRK_OPEN; // RULE6
          end
        end
      end
      BRK_OPEN: state_next = BRK_OPEN;
      default: state_next = BRK_HELD;
    endcase
    if (!enable_i) begin
      state_next = BRK_HELD;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= BRK_HELD;
      enable_d_reg <= 1'b0;
      cyc_reg <= 25'h000_0000;
      ms_left_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      enable_d_reg <= enable_i;
      cyc_reg <= cyc_next;
      ms_left_reg <= ms_left_next;
    end
  end

  assign release_o = state_reg == BRK_OPEN;

endmodule
`default_nettype wire

// >>> design/sab_cmp_if.sv
// sab_cmp_if: operands and result of one hysteresis comparator
// assumes the owner drives all operands from the comparator's clock
`timescale 1ns/1ps
`default_nettype none
interface sab_cmp_if;
  import sab_pkg::*;
  sab_val_t value;
  sab_val_t thresh;
  sab_val_t hyst;
  sab_cmp_mode_e mode;
  logic flag;
  modport owner (output value, output thresh, output hyst, output mode, input flag);
  modport cmp (input value, input thresh, input hyst, input mode, output flag);
endinterface
`default_nettype wire

// >>> design/sab_hyst_cmp.sv
// sab_hyst_cmp: registered comparator with hysteresis, above or below mode
// assumes operands are synchronous to clk_i and non-negative thresholds
`timescale 1ns/1ps
`default_nettype none
module sab_hyst_cmp
  import sab_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  sab_cmp_if.cmp cmp
);

  logic flag_reg;
  logic flag_next;
  logic set_above;
  logic clr_above;
  logic set_below;
  logic clr_below;

  assign set_above = cmp.value > cmp.thresh;
  assign clr_above = cmp.value <= (cmp.thresh - cmp.hyst); // RULE11
  assign set_below = cmp.value < cmp.thresh;
  assign clr_below = cmp.value >= (cmp.thresh + cmp.hyst); // RULE11

  always_comb begin
    flag_next = flag_reg;
    case (cmp.mode)
      CMP_ABOVE: flag_next = flag_reg ? !clr_above : set_above;
      CMP_BELOW: flag_next = flag_reg ? !clr_below : set_below;
      default: flag_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign cmp.flag = flag_reg;

endmodule
`default_nettype wire

// >>> design/sab_pkg.sv
// sab_pkg: constants, types and helpers for the servo arrival/brake block
// assumes one 100 MHz clock shared by all users
package sab_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int CYCLES_PER_MS = (NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int VAL_W = 18;

  // register byte offsets
  localparam logic [7:0] OFF_TORQUE_LEVEL = 8'h00;
  localparam logic [7:0] OFF_TORQUE_HYST = 8'h04;
  localparam logic [7:0] OFF_TORQUE_POL = 8'h08;
  localparam logic [7:0] OFF_ZERO_SPEED = 8'h0C;
  localparam logic [7:0] OFF_BRAKE_DELAY = 8'h10;
  localparam logic [7:0] OFF_ENC_EXP = 8'h14;
  localparam logic [7:0] OFF_POLE_PAIRS = 8'h18;
  localparam logic [7:0] OFF_ZERO_OFFSET = 8'h1C;
  localparam logic [7:0] OFF_MAX_DUTY = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2C;

  // reset values and legal ranges
  localparam int TORQUE_LEVEL_RST = 100;
  localparam int TORQUE_LEVEL_MIN = -300;
  localparam int TORQUE_LEVEL_MAX = 300;
  localparam int TORQUE_HYST_RST = 5;
  localparam int TORQUE_HYST_MIN = 0;
  localparam int TORQUE_HYST_MAX = 300;
  localparam int TORQUE_POL_RST = 0;
  localparam int ZERO_SPEED_RST = 5;
  localparam int ZERO_SPEED_MIN = 0;
  localparam int ZERO_SPEED_MAX = 1000;
  localparam int ZERO_SPEED_HYST_RPM = 2;
  localparam int BRAKE_DELAY_RST = 0;
  localparam int BRAKE_DELAY_MIN = 0;
  localparam int BRAKE_DELAY_MAX = 200;
  localparam int ENC_EXP_RST = 17;
  localparam int ENC_EXP_MIN = 10;
  localparam int ENC_EXP_MAX = 32;
  localparam int POLE_PAIRS_RST = 5;
  localparam int POLE_PAIRS_MIN = 1;
  localparam int POLE_PAIRS_MAX = 360;
  localparam int ZERO_OFFSET_RST = 1800;
  localparam int ZERO_OFFSET_MIN = 0;
  localparam int ZERO_OFFSET_MAX = 3600;
  localparam int MAX_DUTY_RST = 50;
  localparam int MAX_DUTY_MIN = 5;
  localparam int MAX_DUTY_MAX = 90;

  // interrupt bit positions
  localparam int IRQ_TORQUE = 0;
  localparam int IRQ_ZERO_SPEED = 1;
  localparam int IRQ_BRAKE = 2;
  localparam int IRQ_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef logic signed [VAL_W-1:0] sab_val_t;
  typedef enum logic {CMP_ABOVE, CMP_BELOW} sab_cmp_mode_e;
  typedef enum logic [1:0] {BRK_HELD, BRK_WAIT, BRK_OPEN} sab_brake_e;

  // merge a strobed write into the old word, then clamp into range
  function automatic logic signed [31:0] sab_write_field(input logic signed [31:0] old,
      input logic [31:0] data, input logic [3:0] strb, input int lo, input int hi);
    logic signed [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        v[8*b +: 8] = data[8*b +: 8];
      end
    end
    if (v < lo) begin
      v = lo;
    end else if (v > hi) begin
      v = hi;
    end
    return v;
  endfunction

endpackage

// >>> design/sab_servo_status.sv
// sab_servo_status: arrival flags, brake release delay and motor setup
// assumes torque, speed and drive state come from logic on CLOCK_I
// How it works
// RULE1: torque-reached output is high while torque exceeds the arrival level.
// RULE2: torque comparator hysteresis width is a register, 0 to 300, reset 5.
// RULE3: polarity 0 uses magnitude; polarity 1 follows the level's sign.
// RULE4: torque polarity is a single bit register, reset 0.
// RULE5: zero-speed output is high while speed is below threshold, with hysteresis.
// RULE6: after enable, brake release waits the delay register, 0 to 200 ms.
// RULE7: encoder resolution exponent register, 10 to 32, reset 17.
// RULE8: pole-pair count register, 1 to 360, reset 5.
// RULE9: zero-position offset register, 0 to 3600, reset 1800.
// RULE10: braking duty is limited to the max duty register, 5 to 90, reset 50.
// RULE11: a set flag clears only once the value backs off by the hysteresis.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module sab_servo_status
  import sab_pkg::*;
#(
  parameter int CYCLES_PER_MS_P = CYCLES_PER_MS
)(
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic signed [15:0] TORQUE_I,
  input wire logic signed [15:0] SPEED_I,
  input wire logic DRIVE_ENABLE_I,
  input wire logic BRAKING_I,
  input wire logic [6:0] BRAKE_DUTY_REQ_I,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic TORQUE_REACHED_O,
  output logic ZERO_SPEED_O,
  output logic BRAKE_RELEASE_O,
  output logic [6:0] BRAKE_DUTY_O,
  output logic [5:0] ENCODER_EXPONENT_O,
  output logic [8:0] POLE_PAIR_COUNT_O,
  output logic [11:0] ZERO_OFFSET_O,
  output logic [6:0] MAX_BRAKE_DUTY_O,
  output logic IRQ_O
);

  // ---- write channel state
  logic aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic aw_fire;
  logic w_fire;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic wr_mapped;

  // ---- read channel state
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic ar_fire;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_mapped;

  // ---- setup registers
  logic signed [15:0] arrival_torque_level_reg;
  logic [8:0] arrival_torque_hysteresis_reg;
  logic arrival_torque_polarity_reg;
  logic [9:0] zero_speed_threshold_reg;
  logic [7:0] brake_opening_delay_reg;
  logic [5:0] encoder_resolution_exponent_reg;
  logic [8:0] motor_pole_pair_count_reg;
  logic [11:0] zero_position_offset_angle_reg;
  logic [6:0] max_braking_duty_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg;

  // ---- write values after merge and clamp
  logic signed [31:0] lvl_wr;
  logic signed [31:0] hyst_wr;
  logic signed [31:0] pol_wr;
  logic signed [31:0] zsp_wr;
  logic signed [31:0] dly_wr;
  logic signed [31:0] exp_wr;
  logic signed [31:0] pp_wr;
  logic signed [31:0] off_wr;
  logic signed [31:0] duty_wr;
  logic signed [31:0] mask_wr;

  // ---- flag path
  logic torque_reached_flag;
  logic zero_speed_flag;
  logic brake_release_output;
  logic [IRQ_W-1:0] flags_now;
  logic [IRQ_W-1:0] flags_d_reg;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clear;
  logic [6:0] brake_duty_reg;
  logic [6:0] brake_duty_next;

  sab_val_t tq_pos;
  sab_val_t tq_neg;
  sab_val_t lvl_pos;
  sab_val_t lvl_neg;
  sab_val_t spd_pos;
  sab_val_t spd_neg;

  sab_cmp_if torque_cmp ();
  sab_cmp_if speed_cmp ();

  // ---- AXI write: address and data taken in any order
  assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_held_reg && !bvalid_reg;
  assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_fire = S_AXI_WVALID && S_AXI_WREADY;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_addr = {aw_addr_reg[7:2], 2'b00};
  assign wr_mapped = (wr_addr <= OFF_IRQ_MASK) && (wr_addr != OFF_IRQ_STATUS);

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (aw_fire) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (w_fire) begin
      w_held_reg <= 1'b1;
      wdata_reg <= S_AXI_WDATA;
      wstrb_reg <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  // ---- register writes, clamped into each legal range
  assign lvl_wr = sab_write_field(32'(arrival_torque_level_reg), wdata_reg, wstrb_reg,
      TORQUE_LEVEL_MIN, TORQUE_LEVEL_MAX);
  assign hyst_wr = sab_write_field(32'(arrival_torque_hysteresis_reg), wdata_reg,
      wstrb_reg, TORQUE_HYST_MIN, TORQUE_HYST_MAX);
  assign pol_wr = sab_write_field(32'(arrival_torque_polarity_reg), wdata_reg,
      wstrb_reg, 0, 1);
  assign zsp_wr = sab_write_field(32'(zero_speed_threshold_reg), wdata_reg,
      wstrb_reg, ZERO_SPEED_MIN, ZERO_SPEED_MAX);
  assign dly_wr = sab_write_field(32'(brake_opening_delay_reg), wdata_reg,
      wstrb_reg, BRAKE_DELAY_MIN, BRAKE_DELAY_MAX);
  assign exp_wr = sab_write_field(32'(encoder_resolution_exponent_reg), wdata_reg,
      wstrb_reg, ENC_EXP_MIN, ENC_EXP_MAX);
  assign pp_wr = sab_write_field(32'(motor_pole_pair_count_reg), wdata_reg,
      wstrb_reg, POLE_PAIRS_MIN, POLE_PAIRS_MAX);
  assign off_wr = sab_write_field(32'(zero_position_offset_angle_reg), wdata_reg,
      wstrb_reg, ZERO_OFFSET_MIN, ZERO_OFFSET_MAX);
  assign duty_wr = sab_write_field(32'(max_braking_duty_reg), wdata_reg,
      wstrb_reg, MAX_DUTY_MIN, MAX_DUTY_MAX);
  assign mask_wr = sab_write_field(32'(irq_mask_reg), wdata_reg,
      wstrb_reg, 0, 7);

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      arrival_torque_level_reg <= 16'(TORQUE_LEVEL_RST);
      arrival_torque_hysteresis_reg <= 9'(TORQUE_HYST_RST); // RULE2
      arrival_torque_polarity_reg <= 1'(TORQUE_POL_RST); // RULE4
      zero_speed_threshold_reg <= 10'(ZERO_SPEED_RST); // RULE5
      brake_opening_delay_reg <= 8'(BRAKE_DELAY_RST); // RULE6
    end else if (wr_fire) begin
      if (wr_addr == OFF_TORQUE_LEVEL) begin
        arrival_torque_level_reg <= lvl_wr[15:0];
      end
      if (wr_addr == OFF_TORQUE_HYST) begin
        arrival_torque_hysteresis_reg <= hyst_wr[8:0]; // RULE2
      end
      if (wr_addr == OFF_TORQUE_POL) begin
        arrival_torque_polarity_reg <= pol_wr[0]; // RULE4
      end
      if (wr_addr == OFF_ZERO_SPEED) begin
        zero_speed_threshold_reg <= zsp_wr[9:0]; // RULE5
      end
      if (wr_addr == OFF_BRAKE_DELAY) begin
        brake_opening_delay_reg <= dly_wr[7:0]; // RULE6
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      encoder_resolution_exponent_reg <= 6'(ENC_EXP_RST); // RULE7
      motor_pole_pair_count_reg <= 9'(POLE_PAIRS_RST); // RULE8
      zero_position_offset_angle_reg <= 12'(ZERO_OFFSET_RST); // RULE9
      max_braking_duty_reg <= 7'(MAX_DUTY_RST); // RULE10
      irq_mask_reg <= '0;
    end else if (wr_fire) begin
      if (wr_addr == OFF_ENC_EXP) begin
        encoder_resolution_exponent_reg <= exp_wr[5:0]; // RULE7
      end
      if (wr_addr == OFF_POLE_PAIRS) begin
        motor_pole_pair_count_reg <= pp_wr[8:0]; // RULE8
      end
      if (wr_addr == OFF_ZERO_OFFSET) begin
        zero_position_offset_angle_reg <= off_wr[11:0]; // RULE9
      end
      if (wr_addr == OFF_MAX_DUTY) begin
        max_braking_duty_reg <= duty_wr[6:0]; // RULE10
      end
      if (wr_addr == OFF_IRQ_MASK) begin
        irq_mask_reg <= mask_wr[IRQ_W-1:0];
      end
    end
  end

  // ---- AXI read
  assign S_AXI_ARREADY = !rvalid_reg;
  assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_addr = {S_AXI_ARADDR[7:2], 2'b00};
  assign rd_mapped = rd_addr <= OFF_STATUS;

  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      OFF_TORQUE_LEVEL: rd_data = 32'(arrival_torque_level_reg);
      OFF_TORQUE_HYST: rd_data = 32'(arrival_torque_hysteresis_reg);
      OFF_TORQUE_POL: rd_data = 32'(arrival_torque_polarity_reg);
      OFF_ZERO_SPEED: rd_data = 32'(zero_speed_threshold_reg);
      OFF_BRAKE_DELAY: rd_data = 32'(brake_opening_delay_reg);
      OFF_ENC_EXP: rd_data = 32'(encoder_resolution_exponent_reg);
      OFF_POLE_PAIRS: rd_data = 32'(motor_pole_pair_count_reg);
      OFF_ZERO_OFFSET: rd_data = 32'(zero_position_offset_angle_reg);
      OFF_MAX_DUTY: rd_data = 32'(max_braking_duty_reg);
      OFF_IRQ_STATUS: rd_data = 32'(irq_status_reg);
      OFF_IRQ_MASK: rd_data = 32'(irq_mask_reg);
      OFF_STATUS: rd_data = {28'h000_0000, DRIVE_ENABLE_I, flags_now};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // ---- torque comparator operands
  assign tq_pos = VAL_W'(TORQUE_I);
  assign tq_neg = -tq_pos;
  assign lvl_pos = VAL_W'(arrival_torque_level_reg);
  assign lvl_neg = -lvl_pos;

  always_comb begin
    torque_cmp.mode = CMP_ABOVE; // RULE1
    torque_cmp.hyst = VAL_W'({1'b0, arrival_torque_hysteresis_reg}); // RULE2
    torque_cmp.thresh = lvl_pos[VAL_W-1] ? lvl_neg : lvl_pos;
    if (!arrival_torque_polarity_reg) begin
      torque_cmp.value = tq_pos[VAL_W-1] ? tq_neg : tq_pos; // RULE3
    end else begin
      torque_cmp.value = lvl_pos[VAL_W-1] ? tq_neg : tq_pos; // RULE3
    end
  end

  // ---- zero-speed comparator operands
  assign spd_pos = VAL_W'(SPEED_I);
  assign spd_neg = -spd_pos;
  assign speed_cmp.mode = CMP_BELOW; // RULE5
  assign speed_cmp.value = spd_pos[VAL_W-1] ? spd_neg : spd_pos;
  assign speed_cmp.thresh = VAL_W'({1'b0, zero_speed_threshold_reg});
  assign speed_cmp.hyst = VAL_W'(ZERO_SPEED_HYST_RPM);

  sab_hyst_cmp u_torque_cmp (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .cmp(torque_cmp.cmp)
  );

  sab_hyst_cmp u_speed_cmp (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .cmp(speed_cmp.cmp)
  );

  assign torque_reached_flag = torque_cmp.flag; // RULE1
  assign zero_speed_flag = speed_cmp.flag; // RULE5

  sab_brake_timer #(
    .CYCLES_PER_MS_P(CYCLES_PER_MS_P)
  ) u_brake_timer (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .enable_i(DRIVE_ENABLE_I),
    .delay_ms_i(brake_opening_delay_reg),
    .release_o(brake_release_output)
  );

  // ---- braking duty limit
  assign brake_duty_next = !BRAKING_I ? 7'h00 :
      (BRAKE_DUTY_REQ_I > max_braking_duty_reg) ? max_braking_duty_reg :
      BRAKE_DUTY_REQ_I; // RULE10

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      brake_duty_reg <= 7'h00;
    end else begin
      brake_duty_reg <= brake_duty_next;
    end
  end

  // ---- interrupts: rising flags set sticky bits, a status read clears
  assign flags_now = {brake_release_output, zero_speed_flag, torque_reached_flag};
  assign irq_events = flags_now & ~flags_d_reg;
  assign irq_clear = (ar_fire && rd_addr == OFF_IRQ_STATUS) ? {IRQ_W{1'b1}} : '0;
  assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      flags_d_reg <= '0;
      irq_status_reg <= '0;
    end else begin
      flags_d_reg <= flags_now;
      irq_status_reg <= irq_status_next;
    end
  end

  assign IRQ_O = |(irq_status_reg & irq_mask_reg);

  // ---- outputs
  assign TORQUE_REACHED_O = torque_reached_flag;
  assign ZERO_SPEED_O = zero_speed_flag;
  assign BRAKE_RELEASE_O = brake_release_output;
  assign BRAKE_DUTY_O = brake_duty_reg;
  assign ENCODER_EXPONENT_O = encoder_resolution_exponent_reg;
  assign POLE_PAIR_COUNT_O = motor_pole_pair_count_reg;
  assign ZERO_OFFSET_O = zero_position_offset_angle_reg;
  assign MAX_BRAKE_DUTY_O = max_braking_duty_reg;

endmodule
`default_nettype wire

// >>> sim/sab_ctrl_model.sv
// sab_ctrl_model: controller counting brake releases on its terminal
// assumes the terminal is sampled on the drive clock
`timescale 1ns/1ps
`default_nettype none
module sab_ctrl_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic brake_i,
  output int rises_o
);
  logic brake_q;
  always_ff @(posedge clk_i) begin
    brake_q <= brake_i;
    if (rst_i) begin
      rises_o <= 0;
    end else if (brake_i && !brake_q) begin
      rises_o <= rises_o + 1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/sab_servo_status_sva.sv
// sab_servo_status_sva: port checks of the servo status block
// assumes it is bound into sab_servo_status
`timescale 1ns/1ps
`default_nettype none
module sab_servo_status_sva (
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic signed [15:0] SPEED_I,
  input wire logic DRIVE_ENABLE_I,
  input wire logic BRAKING_I,
  input wire logic [6:0] BRAKE_DUTY_REQ_I,
  input wire logic ZERO_SPEED_O,
  input wire logic BRAKE_RELEASE_O,
  input wire logic [6:0] BRAKE_DUTY_O,
  input wire logic [5:0] ENCODER_EXPONENT_O,
  input wire logic [8:0] POLE_PAIR_COUNT_O,
  input wire logic [11:0] ZERO_OFFSET_O,
  input wire logic [6:0] MAX_BRAKE_DUTY_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  a_duty_idle: assert property (
    !BRAKING_I |=> BRAKE_DUTY_O == 7'h00) else $error("duty not zero");
  a_duty_cap: assert property (
    BRAKING_I |=> BRAKE_DUTY_O <= $past(MAX_BRAKE_DUTY_O)) else $error("duty over max");
  a_duty_pass: assert property (
    BRAKING_I && BRAKE_DUTY_REQ_I <= MAX_BRAKE_DUTY_O |=> BRAKE_DUTY_O == $past(BRAKE_DUTY_REQ_I))
    else $error("duty not passed");
  a_brake_drop: assert property (
    !DRIVE_ENABLE_I |=> !BRAKE_RELEASE_O) else $error("brake open while off");
  a_brake_cause: assert property (
    $rose(BRAKE_RELEASE_O) |-> $past(DRIVE_ENABLE_I)) else $error("brake opened unasked");
  a_fast_nozero: assert property (
    SPEED_I > 16'sh03e9 || SPEED_I < -16'sh03e9 |=> !ZERO_SPEED_O) else $error("zero speed");
  a_exp_range: assert property (
    ENCODER_EXPONENT_O inside {[6'h0a:6'h20]}) else $error("exponent range");
  a_pole_range: assert property (
    POLE_PAIR_COUNT_O inside {[9'h001:9'h168]}) else $error("pole range");
  a_offset_range: assert property (
    ZERO_OFFSET_O <= 12'he10) else $error("offset range");
  a_maxduty_range: assert property (
    MAX_BRAKE_DUTY_O inside {[7'h05:7'h5a]}) else $error("max duty range");
endmodule
bind sab_servo_status sab_servo_status_sva sva_inst (.*);
`default_nettype wire

// >>> sim/sab_servo_status_tb_top.sv
// sab_servo_status_tb_top: self-checking bench of the servo status block
// assumes the checker binds itself in
`timescale 1ns/1ps
`default_nettype none
module sab_servo_status_tb_top;
  import sab_pkg::*;
  localparam logic [1:0] OK = RESP_OKAY;
  localparam logic [1:0] ER = RESP_SLVERR;
  logic c = 0, r = 1, en = 0, bk = 0, awv = 0, wv = 0, bre = 1, arv = 0, rre = 1;
  logic signed [15:0] tq = 0, sp = 16'sh0064;
  logic [6:0] req = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic awr, wrd, bv, arr, rv, tro, zso, bro, irq;
  logic [1:0] br, rr;
  logic [31:0] rdt;
  logic [6:0] duty, mdo;
  logic [5:0] exo;
  logic [8:0] ppo;
  logic [11:0] ofo;
  int rises, mismatches = 0, checked = 0;
  always #5 c = ~c;
  sab_servo_status #(.CYCLES_PER_MS_P(4)) sab_servo_status_inst (.CLOCK_I(c), .RESET_I(r),
    .TORQUE_I(tq), .SPEED_I(sp), .DRIVE_ENABLE_I(en), .BRAKING_I(bk), .BRAKE_DUTY_REQ_I(req),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rre), .TORQUE_REACHED_O(tro), .ZERO_SPEED_O(zso), .BRAKE_RELEASE_O(bro),
    .BRAKE_DUTY_O(duty), .ENCODER_EXPONENT_O(exo), .POLE_PAIR_COUNT_O(ppo),
    .ZERO_OFFSET_O(ofo), .MAX_BRAKE_DUTY_O(mdo), .IRQ_O(irq));
  sab_ctrl_model sab_ctrl_model_inst (.clk_i(c), .rst_i(r), .brake_i(bro), .rises_o(rises));
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    do begin
      @(posedge c);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    chk("bresp", 32'(br), 32'(e));
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    ara <= a;
    arv <= 1;
    do begin
      @(posedge c);
      if (arr) arv <= 0;
    end while (!rv);
    chk("rdata", rdt, e);
    chk("rresp", 32'(rr), 32'(er));
  endtask
  task automatic drv(input logic t, input logic signed [15:0] v, input logic e);
    if (t) tq <= v;
    else sp <= v;
    repeat (2) @(posedge c);
    chk("flag", 32'(t ? tro : zso), 32'(e));
  endtask
  task automatic wait_brk(input int e);
    int n;
    n = 0;
    en <= 1;
    do begin
      @(posedge c);
      n++;
    end while (!bro && n < 99);
    chk("brake wait", 32'(n), 32'(e));
  endtask
  task automatic t_reset;
    rreg(OFF_TORQUE_HYST, 32'h0000_0005, OK);
    rreg(OFF_TORQUE_POL, 32'h0000_0000, OK);
    rreg(OFF_ZERO_SPEED, 32'h0000_0005, OK);
    rreg(OFF_BRAKE_DELAY, 32'h0000_0000, OK);
    chk("exponent", 32'(exo), 32'h0000_0011);
    chk("poles", 32'(ppo), 32'h0000_0005);
    chk("offset", 32'(ofo), 32'h0000_0708);
    chk("max duty", 32'(mdo), 32'h0000_0032);
    rreg(8'h30, 32'h0000_0000, ER);
  endtask
  task automatic t_clamp;
    wreg(OFF_ENC_EXP, 32'h0000_0028, OK);
    chk("exponent", 32'(exo), 32'h0000_0020);
    wreg(OFF_ENC_EXP, 32'h0000_0009, OK);
    chk("exponent", 32'(exo), 32'h0000_000a);
    wreg(OFF_POLE_PAIRS, 32'h0000_0169, OK);
    chk("poles", 32'(ppo), 32'h0000_0168);
    wreg(OFF_ZERO_OFFSET, 32'h0000_0e11, OK);
    chk("offset", 32'(ofo), 32'h0000_0e10);
    wreg(OFF_MAX_DUTY, 32'h0000_0004, OK);
    chk("max duty", 32'(mdo), 32'h0000_0005);
    wreg(OFF_MAX_DUTY, 32'h0000_005b, OK);
    chk("max duty", 32'(mdo), 32'h0000_005a);
    wreg(OFF_TORQUE_HYST, 32'h0000_012d, OK);
    rreg(OFF_TORQUE_HYST, 32'h0000_012c, OK);
    wreg(OFF_TORQUE_HYST, 32'h0000_0005, OK);
    wreg(OFF_STATUS, 32'h0000_0001, ER);
  endtask
  task automatic t_torque;
    drv(1, -16'sh0065, 1);
    drv(1, -16'sh0060, 1);
    drv(1, -16'sh005f, 0);
    drv(1, 16'sh0064, 0);
    wreg(OFF_TORQUE_POL, 32'h0000_0001, OK);
    drv(1, -16'sh0096, 0);
    drv(1, 16'sh0096, 1);
    wreg(OFF_TORQUE_LEVEL, 32'hffff_ff9c, OK);
    drv(1, 16'sh0096, 0);
    drv(1, -16'sh0096, 1);
  endtask
  task automatic t_zero;
    rreg(OFF_IRQ_STATUS, 32'h0000_0001, OK);
    wreg(OFF_IRQ_MASK, 32'h0000_0002, OK);
    drv(0, -16'sh0003, 1);
    @(posedge c);
    chk("irq", 32'(irq), 32'h0000_0001);
    drv(0, 16'sh0006, 1);
    drv(0, 16'sh0007, 0);
    rreg(OFF_IRQ_STATUS, 32'h0000_0002, OK);
    repeat (2) @(posedge c);
    chk("irq", 32'(irq), 32'h0000_0000);
    wreg(OFF_IRQ_MASK, 32'h0000_0000, OK);
    drv(0, 16'sh0004, 1);
    @(posedge c);
    chk("irq", 32'(irq), 32'h0000_0000);
    drv(0, -16'sh07d0, 0);
  endtask
  task automatic t_brake;
    bk <= 1;
    req <= 7'h14;
    wreg(OFF_BRAKE_DELAY, 32'h0000_00c9, OK);
    rreg(OFF_BRAKE_DELAY, 32'h0000_00c8, OK);
    wreg(OFF_BRAKE_DELAY, 32'h0000_0002, OK);
    wait_brk(10);
    req <= 7'h64;
    repeat (2) @(posedge c);
    chk("duty", 32'(duty), 32'h0000_005a);
    bk <= 0;
    en <= 0;
    repeat (2) @(posedge c);
    chk("brake", 32'(bro), 32'h0000_0000);
    chk("duty", 32'(duty), 32'h0000_0000);
    wreg(OFF_BRAKE_DELAY, 32'h0000_0000, OK);
    wait_brk(2);
    @(posedge c);
    chk("releases", 32'(rises), 32'h0000_0002);
  endtask
  initial begin
    repeat (16) @(posedge c);
    r <= 0;
    @(posedge c);
    t_reset;
    t_clamp;
    t_torque;
    t_zero;
    t_brake;
    close_out;
  end
  initial begin
    #200000;
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
